/* rtl/wdt_top.sv */
// Function
// R01 - Window mode: any service write in first three quarters requests reset.
// R02 - Repeated first keys allowed in window; completed pair restarts and closes window.
// R03 - Window select bit: 0 normal operation, 1 windowed operation.
// R04 - Stop-in-debug set halts watchdog and tick counters during debug.
// R05 - Write-mask bit set leaves window and rate untouched, no write-once use.
// R06 - Nonzero rate write enables counting with fresh period; zero disables.
// R07 - Counter reaching time-out unserviced raises reset request.
// R08 - Enabled, debug, stop bit clear, special mode: longest period, normal mode.
// R09 - Rate codes 1..7 give 2^14,16,18,20,22,23,24 count cycles.
// R10 - Count clock chosen between internal RC and crystal by select bit.
// R11 - Service register always reads zero, writable any time.
// R12 - Service writes ignored while rate is zero.
// R13 - Enabled: service value other than either key requests reset.
// R14 - First key then second key restarts period; repeated first keys fine.
// R15 - Factory test registers readable always, writable only in special mode.
// R16 - Normal mode: only first unmasked write changes window and rate fields.
// R17 - Stop-in-debug freely writable in special mode, only settable in normal.
// R18 - Special mode control writes, clock select change, oscillator loss restart.
// R19 - After reset, fields loaded from memory; nonzero rate starts period.
// R20 - Reset request is single bus-clock pulse.
module wdt_top
    import wdt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic special_mode,
    input wire logic background_debug,
    input wire logic oscillator_good,
    input wire logic wd_clock_select,
    input wire logic internal_rc_clock,
    input wire logic crystal_osc_clock,
    input wire logic nvm_window,
    input wire logic [2:0] nvm_rate,
    output logic wd_reset_req,
    output logic tick_halt
);

    typedef enum logic [1:0] {
        WDT_LOAD = 2'b00,
        WDT_RUN = 2'b01
    } wdt_state_e;

    wdt_state_e state_r, state_nxt;
    logic window_r, window_nxt;
    logic stopdbg_r, stopdbg_nxt;
    logic [2:0] rate_r, rate_nxt;
    logic once_used_r, once_used_nxt;
    logic [WDT_CNT_W-1:0] cnt_r, cnt_nxt;
    logic key1_r, key1_nxt;
    logic [7:0] test_a_r, test_a_nxt;
    logic [7:0] test_b_r, test_b_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic req_r, req_nxt;
    logic halt_r, halt_nxt;
    logic [1:0] dbg_sync_r, dbg_sync_nxt;
    logic [1:0] osc_sync_r, osc_sync_nxt;
    logic [1:0] smode_sync_r, smode_sync_nxt;
    logic osc_last_r, osc_last_nxt;
    logic sel_last_r, sel_last_nxt;
    logic [1:0] sel_sync_r, sel_sync_nxt;

    logic tick;
    logic dbg, smode;
    logic enabled, forced, eff_window;
    logic [2:0] eff_rate;
    logic [WDT_CNT_W:0] period;
    logic [WDT_CNT_W:0] win_open;
    logic in_window, timeout;
    logic ctrl_wr, svc_wr, test_a_wr, test_b_wr;
    logic field_wr, restart, fault, pair_done, halted;

    // Period in count cycles for a rate code
    // One bit wider than the counter so the longest period fits
    function automatic logic [WDT_CNT_W:0] wdt_period(input logic [2:0] code);
        wdt_period = (WDT_CNT_W+1)'(1) << wdt_rate_log2(code); // R09
    endfunction

    // Count clock pick; the select arrives already synchronised so
    // the source mux never sees a metastable level
    wdt_clk_sel u_clk_sel (
        .clk(clk),
        .resetn(resetn),
        .internal_rc_clock(internal_rc_clock),
        .crystal_osc_clock(crystal_osc_clock),
        .wd_clock_select(sel_sync_r[1]), // R10
        .tick(tick)
    );

    // ----------------------------------------
    // Decode and effective mode
    // ----------------------------------------
    always_comb begin
        dbg = dbg_sync_r[1];
        smode = smode_sync_r[1];
        halted = stopdbg_r && dbg; // R04
        ctrl_wr = wr_en && (addr == WDT_OFF_CONTROL);
        svc_wr = wr_en && (addr == WDT_OFF_SERVICE);
        test_a_wr = wr_en && (addr == WDT_OFF_TEST_A) && smode; // R15
        test_b_wr = wr_en && (addr == WDT_OFF_TEST_B) && smode; // R15
        enabled = (rate_r != WDT_RATE_OFF); // R06
        forced = enabled && dbg && !stopdbg_r && smode; // R08
        eff_rate = forced ? WDT_RATE_MAX : rate_r; // R08
        eff_window = forced ? 1'b0 : window_r; // R03 R08
        period = wdt_period(eff_rate);
        // Window opens at three quarters of the effective period
        win_open = period - (period >> 2); // R01
        in_window = ({1'b0, cnt_r} >= win_open);
        timeout = enabled && !halted && ({1'b0, cnt_r} >= period - 1'b1) && tick; // R07
        field_wr = ctrl_wr && !wdata[WDT_BIT_WMASK] && (smode || !once_used_r); // R05 R16
    end

    // ----------------------------------------
    // Control register and write-once logic
    // ----------------------------------------
    // Stop bit is sticky in normal mode; fields pass the write-once gate
    always_comb begin
        state_nxt = state_r;
        window_nxt = window_r;
        rate_nxt = rate_r;
        stopdbg_nxt = stopdbg_r;
        once_used_nxt = once_used_r;
        restart = 1'b0;
        case (state_r)
            WDT_LOAD: begin
                window_nxt = nvm_window; // R19
                rate_nxt = nvm_rate; // R19
                restart = 1'b1; // R19
                state_nxt = WDT_RUN;
            end
            WDT_RUN: begin
                if (field_wr) begin
                    window_nxt = wdata[WDT_BIT_WINDOW];
                    rate_nxt = wdata[WDT_RATE_HI:WDT_RATE_LO];
                    once_used_nxt = 1'b1; // R16
                    if (wdata[WDT_RATE_HI:WDT_RATE_LO] != WDT_RATE_OFF) begin
                        restart = 1'b1; // R06
                    end
                    if (wdata[WDT_BIT_WINDOW]) begin
                        restart = 1'b1;
                    end
                end
                if (ctrl_wr) begin
                    if (smode) begin
                        stopdbg_nxt = wdata[WDT_BIT_STOPDBG]; // R17
                        restart = 1'b1; // R18
                    end else if (wdata[WDT_BIT_STOPDBG]) begin
                        stopdbg_nxt = 1'b1; // R17
                        if (!stopdbg_r) begin
                            restart = 1'b1;
                        end
                    end
                end
                if ((sel_sync_r[1] != sel_last_r) || (osc_last_r && !osc_sync_r[1])) begin
                    restart = 1'b1; // R18
                end
            end
            default: state_nxt = WDT_LOAD;
        endcase
    end

    // Control register state
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= WDT_LOAD;
            window_r <= 1'b0;
            stopdbg_r <= 1'b0;
            rate_r <= WDT_RATE_OFF;
            once_used_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            window_r <= window_nxt;
            stopdbg_r <= stopdbg_nxt;
            rate_r <= rate_nxt;
            once_used_r <= once_used_nxt;
        end
    end

    // ----------------------------------------
    // Counter and service sequence
    // ----------------------------------------
    // A second key with no pending first key is simply ignored
    always_comb begin
        cnt_nxt = cnt_r;
        key1_nxt = key1_r;
        fault = 1'b0;
        pair_done = 1'b0;
        if (svc_wr && enabled) begin // R12
            if (eff_window && !in_window) begin
                fault = 1'b1; // R01
            end else if (wdata == WDT_KEY_FIRST) begin
                key1_nxt = 1'b1; // R02 R14
            end else if (wdata == WDT_KEY_SECOND) begin
                pair_done = key1_r; // R02 R14
            end else begin
                fault = 1'b1; // R13
            end
        end
        // Any clear also drops the key state, so a stale first key
        // cannot pair with a later second key
        if (restart || pair_done || timeout || !enabled) begin
            cnt_nxt = '0; // R02 R14
            key1_nxt = 1'b0;
        end else if (tick && !halted) begin // R04
            cnt_nxt = cnt_r + 1'b1;
        end
        // Pulse only: back-to-back faults must not merge into a level
        req_nxt = (fault || timeout) && !req_r; // R07 R20
        halt_nxt = halted; // R04
    end

    // Counter state registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_r <= '0;
            key1_r <= 1'b0;
            req_r <= 1'b0;
            halt_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            key1_r <= key1_nxt;
            req_r <= req_nxt;
            halt_r <= halt_nxt;
        end
    end

    // ----------------------------------------
    // Test registers and read path
    // ----------------------------------------
    // Read data is zero outside the cycle after a read strobe
    always_comb begin
        test_a_nxt = test_a_wr ? wdata : test_a_r;
        test_b_nxt = test_b_wr ? wdata : test_b_r;
        rdata_nxt = WDT_ZERO_BYTE;
        if (rd_en) begin
            case (addr)
                WDT_OFF_CONTROL: rdata_nxt = {window_r, stopdbg_r, 3'h0, rate_r};
                WDT_OFF_TEST_A: rdata_nxt = test_a_r; // R15
                WDT_OFF_TEST_B: rdata_nxt = test_b_r; // R15
                WDT_OFF_SERVICE: rdata_nxt = WDT_ZERO_BYTE; // R11
                default: rdata_nxt = WDT_ZERO_BYTE;
            endcase
        end
    end

    // Test and read data registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            test_a_r <= WDT_ZERO_BYTE;
            test_b_r <= WDT_ZERO_BYTE;
            rdata_r <= WDT_ZERO_BYTE;
        end else begin
            test_a_r <= test_a_nxt;
            test_b_r <= test_b_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Pin synchronisers and edge history
    // ----------------------------------------
    // Only the second stage of each chain feeds any logic
    always_comb begin
        dbg_sync_nxt = {dbg_sync_r[0], background_debug};
        osc_sync_nxt = {osc_sync_r[0], oscillator_good};
        smode_sync_nxt = {smode_sync_r[0], special_mode};
        sel_sync_nxt = {sel_sync_r[0], wd_clock_select};
        osc_last_nxt = osc_sync_r[1];
        sel_last_nxt = sel_sync_r[1];
    end

    // Synchroniser registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dbg_sync_r <= 2'h0;
            osc_sync_r <= 2'h0;
            smode_sync_r <= 2'h0;
            sel_sync_r <= 2'h0;
            osc_last_r <= 1'b0;
            sel_last_r <= 1'b0;
        end else begin
            dbg_sync_r <= dbg_sync_nxt;
            osc_sync_r <= osc_sync_nxt;
            smode_sync_r <= smode_sync_nxt;
            sel_sync_r <= sel_sync_nxt;
            osc_last_r <= osc_last_nxt;
            sel_last_r <= sel_last_nxt;
        end
    end

    assign rdata = rdata_r;
    assign wd_reset_req = req_r;
    assign tick_halt = halt_r;

endmodule

/* rtl/wdt_pkg.sv */
package wdt_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] WDT_OFF_CONTROL = 8'h3C;
    localparam logic [7:0] WDT_OFF_TEST_A = 8'h3D;
    localparam logic [7:0] WDT_OFF_TEST_B = 8'h3E;
    localparam logic [7:0] WDT_OFF_SERVICE = 8'h3F;

    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int WDT_BIT_WINDOW = 7;
    localparam int WDT_BIT_STOPDBG = 6;
    localparam int WDT_BIT_WMASK = 5;
    localparam int WDT_RATE_HI = 2;
    localparam int WDT_RATE_LO = 0;

    // ----------------------------------------
    // Values and keys
    // ----------------------------------------
    localparam logic [2:0] WDT_RATE_OFF = 3'h0;
    localparam logic [2:0] WDT_RATE_MAX = 3'h7;
    localparam logic [7:0] WDT_KEY_FIRST = 8'h55;
    localparam logic [7:0] WDT_KEY_SECOND = 8'hAA;
    localparam logic [7:0] WDT_ZERO_BYTE = 8'h00;
    localparam int WDT_CNT_W = 24;

    // Rate code to log2 of time-out length
    function automatic logic [4:0] wdt_rate_log2(input logic [2:0] code);
        case (code)
            3'h1: wdt_rate_log2 = 5'h0E;
            3'h2: wdt_rate_log2 = 5'h10;
            3'h3: wdt_rate_log2 = 5'h12;
            3'h4: wdt_rate_log2 = 5'h14;
            3'h5: wdt_rate_log2 = 5'h16;
            3'h6: wdt_rate_log2 = 5'h17;
            3'h7: wdt_rate_log2 = 5'h18;
            default: wdt_rate_log2 = 5'h00;
        endcase
    endfunction

endpackage

/* rtl/wdt_clk_sel.sv */
// Picks the watchdog count clock as a synchronised enable pulse
module wdt_clk_sel
    import wdt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic internal_rc_clock,
    input wire logic crystal_osc_clock,
    input wire logic wd_clock_select,
    output logic tick
);

    logic [1:0] rc_sync_r, rc_sync_nxt;
    logic [1:0] xo_sync_r, xo_sync_nxt;
    logic last_r, last_nxt;
    logic tick_r, tick_nxt;
    logic sel_lvl;

    // ----------------------------------------
    // Synchronise both sources, edge detect on the chosen one
    // ----------------------------------------
    always_comb begin
        rc_sync_nxt = {rc_sync_r[0], internal_rc_clock};
        xo_sync_nxt = {xo_sync_r[0], crystal_osc_clock};
        sel_lvl = wd_clock_select ? xo_sync_r[1] : rc_sync_r[1]; // R10
        last_nxt = sel_lvl;
        tick_nxt = sel_lvl & ~last_r;
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rc_sync_r <= 2'h0;
            xo_sync_r <= 2'h0;
            last_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            rc_sync_r <= rc_sync_nxt;
            xo_sync_r <= xo_sync_nxt;
            last_r <= last_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule

/* bench/wdt_checker.sv */
module wdt_checker
    import wdt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic background_debug,
    input wire logic wd_reset_req,
    input wire logic tick_halt
);
    logic ctl_rd_r, ctl_rd_nxt, ok_r, ok_nxt;
    logic [7:0] ctl_r, ctl_nxt;
    logic svc_wr, svc_key;

    // Service write decode
    assign svc_wr = wr_en && (addr == WDT_OFF_SERVICE);
    assign svc_key = (wdata == WDT_KEY_FIRST) || (wdata == WDT_KEY_SECOND);

    // Shadow of the last control value read back
    always_comb begin
        ctl_rd_nxt = rd_en && (addr == WDT_OFF_CONTROL);
        ctl_nxt = ctl_rd_r ? rdata : ctl_r;
        ok_nxt = ok_r || ctl_rd_r;
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctl_rd_r <= 1'b0;
            ctl_r <= 8'h00;
            ok_r <= 1'b0;
        end else begin
            ctl_rd_r <= ctl_rd_nxt;
            ctl_r <= ctl_nxt;
            ok_r <= ok_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_rdata_idle: assert property (!rd_en |=> rdata == WDT_ZERO_BYTE)
        else $error("rdata not zero outside a read");
    chk_unmapped_zero: assert property (rd_en && (addr < WDT_OFF_CONTROL ||
        addr > WDT_OFF_SERVICE) |=> rdata == WDT_ZERO_BYTE)
        else $error("unmapped read not zero");
    chk_service_reads_zero: assert property (
        rd_en && addr == WDT_OFF_SERVICE |=> rdata == WDT_ZERO_BYTE)
        else $error("service read not zero");
    chk_mask_reads_zero: assert property (
        rd_en && addr == WDT_OFF_CONTROL |=> rdata[5:3] == 3'h0)
        else $error("control mask or unused bits read nonzero");
    chk_req_pulse: assert property (wd_reset_req |=> !wd_reset_req)
        else $error("reset request longer than one cycle");
    chk_bad_key: assert property (
        svc_wr && !svc_key && ok_r && ctl_r[2:0] != WDT_RATE_OFF && !wd_reset_req
        |=> wd_reset_req)
        else $error("bad service value without reset request");
    chk_good_key: assert property (
        svc_wr && svc_key && ok_r && !ctl_r[WDT_BIT_WINDOW] |=> !wd_reset_req)
        else $error("key write raised reset request");
    chk_halt_set: assert property (
        (background_debug && ok_r && ctl_r[WDT_BIT_STOPDBG])[*5] |-> tick_halt)
        else $error("tick halt missing in debug");
    chk_halt_clear: assert property ((!background_debug)[*5] |-> !tick_halt)
        else $error("tick halt outside debug");

    // Main scenarios
    cover property (wd_reset_req);
    cover property ($rose(tick_halt));
    cover property (ctl_rd_r && rdata[WDT_BIT_WINDOW]);
endmodule

bind wdt_top wdt_checker u_chk (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .background_debug(background_debug),
    .wd_reset_req(wd_reset_req), .tick_halt(tick_halt)
);

/* bench/test_wdt_top.sv */
module test_wdt_top
    import wdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals and design
    // ----------------------------------------
    localparam real XTAL_HALF = 90.0;
    logic clk, resetn, wr_en, rd_en, special_mode, background_debug, oscillator_good;
    logic wd_clock_select, internal_rc_clock, crystal_osc_clock, nvm_window;
    logic wd_reset_req, tick_halt;
    logic [7:0] addr, wdata, rdata, rd_val;
    logic [2:0] nvm_rate;
    int errors = 0;
    int samples_checked = 0;

    wdt_top DUT (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .special_mode(special_mode),
        .background_debug(background_debug), .oscillator_good(oscillator_good),
        .wd_clock_select(wd_clock_select), .internal_rc_clock(internal_rc_clock),
        .crystal_osc_clock(crystal_osc_clock), .nvm_window(nvm_window),
        .nvm_rate(nvm_rate), .wd_reset_req(wd_reset_req), .tick_halt(tick_halt)
    );

    // Bus clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Slow count clocks, crystal offset in phase
    initial begin
        crystal_osc_clock = 1'b0;
        #7;
        forever #(XTAL_HALF) crystal_osc_clock = ~crystal_osc_clock;
    end
    initial begin
        internal_rc_clock = 1'b0;
        forever #150 internal_rc_clock = ~internal_rc_clock;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out();
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic do_reset(logic w, logic [2:0] r, int n);
        resetn <= 1'b0;
        nvm_window <= w;
        nvm_rate <= r;
        repeat (n) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // Write, then note the request seen in the following cycle
    task automatic wr_chk(string n, logic [7:0] a, logic [7:0] d, logic exp_req);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
        check(n, {7'h00, exp_req}, {7'h00, wd_reset_req});
        @(posedge clk);
    endtask

    task automatic rd(logic [7:0] a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        rd_val = rdata;
        @(posedge clk);
    endtask

    task automatic rd_chk(string n, logic [7:0] a, logic [7:0] exp);
        rd(a);
        check(n, exp, rd_val);
    endtask

    task automatic halt_step(logic dbg);
        background_debug <= dbg;
        repeat (6) @(posedge clk);
        #1;
        check("tick halt", {7'h00, dbg}, {7'h00, tick_halt});
        @(posedge clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [7:0] keep;
        rd_chk("ctrl after load", WDT_OFF_CONTROL, 8'h00);
        wr_chk("svc when off", WDT_OFF_SERVICE, 8'h12, 1'b0);
        rd_chk("svc read", WDT_OFF_SERVICE, WDT_ZERO_BYTE);
        rd_chk("unmapped", 8'h10, WDT_ZERO_BYTE);
        rd(WDT_OFF_TEST_A);
        keep = rd_val;
        wr_chk("test a write", WDT_OFF_TEST_A, ~keep, 1'b0);
        rd_chk("test a kept", WDT_OFF_TEST_A, keep);
        special_mode <= 1'b1;
        repeat (3) @(posedge clk);
        wr_chk("test a special", WDT_OFF_TEST_A, 8'h5A, 1'b0);
        rd_chk("test a special", WDT_OFF_TEST_A, 8'h5A);
        wr_chk("stop special", WDT_OFF_CONTROL, 8'h60, 1'b0);
        rd_chk("stop special", WDT_OFF_CONTROL, 8'h40);
        wr_chk("stop clr special", WDT_OFF_CONTROL, 8'h20, 1'b0);
        rd_chk("stop clr special", WDT_OFF_CONTROL, 8'h00);
        special_mode <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_ctrl();
        wr_chk("masked ctrl", WDT_OFF_CONTROL, 8'hA3, 1'b0);
        rd_chk("masked ctrl", WDT_OFF_CONTROL, 8'h00);
        wr_chk("rate one", WDT_OFF_CONTROL, 8'h01, 1'b0);
        rd_chk("rate one", WDT_OFF_CONTROL, 8'h01);
        wr_chk("second write", WDT_OFF_CONTROL, 8'h87, 1'b0);
        rd_chk("second write", WDT_OFF_CONTROL, 8'h01);
        wr_chk("stop set", WDT_OFF_CONTROL, 8'h41, 1'b0);
        rd_chk("stop set", WDT_OFF_CONTROL, 8'h41);
        wr_chk("stop clear", WDT_OFF_CONTROL, 8'h01, 1'b0);
        rd_chk("stop clear", WDT_OFF_CONTROL, 8'h41);
        wr_chk("key first", WDT_OFF_SERVICE, WDT_KEY_FIRST, 1'b0);
        wr_chk("key first again", WDT_OFF_SERVICE, WDT_KEY_FIRST, 1'b0);
        wr_chk("key second", WDT_OFF_SERVICE, WDT_KEY_SECOND, 1'b0);
        wr_chk("lone second", WDT_OFF_SERVICE, WDT_KEY_SECOND, 1'b0);
        wr_chk("bad key", WDT_OFF_SERVICE, 8'h13, 1'b1);
        halt_step(1'b1);
        halt_step(1'b0);
    endtask

    task automatic t_window();
        do_reset(1'b1, 3'h1, 2);
        rd_chk("window load", WDT_OFF_CONTROL, 8'h81);
        wr_chk("early key", WDT_OFF_SERVICE, WDT_KEY_FIRST, 1'b1);
    endtask

    task automatic t_timeout();
        realtime t0;
        int span;
        do_reset(1'b1, 3'h1, 2);
        t0 = $realtime;
        repeat (56000) @(posedge clk);
        wr_chk("window key", WDT_OFF_SERVICE, WDT_KEY_FIRST, 1'b0);
        wr_chk("window key again", WDT_OFF_SERVICE, WDT_KEY_FIRST, 1'b0);
        repeat (26000) begin
            @(posedge clk);
            #1;
            if (wd_reset_req === 1'b1) break;
        end
        span = int'(($realtime - t0) / (2.0 * XTAL_HALF));
        check("timeout span", 8'h01, {7'h00, span >= 16380 && span <= 16386});
    endtask

    // Main sequence
    initial begin
        resetn = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        special_mode = 1'b0;
        background_debug = 1'b0;
        oscillator_good = 1'b1;
        wd_clock_select = 1'b1;
        nvm_window = 1'b0;
        nvm_rate = 3'h0;
        do_reset(1'b0, 3'h0, 20);
        t_regs();
        t_ctrl();
        t_window();
        t_timeout();
        close_out();
    end

    // Hang guard
    initial begin
        #3600000;
        errors++;
        close_out();
    end
endmodule
